/* resolver_angle_speed_generator.sv */
// resolver angle and speed generator: angle core, waveform table, sample queue, serial drain
`timescale 1ns/1ps
`include "resolver_consts.svh"

// Function
// - step after programmed 32-bit tick interval
// - fixed angle index 0..1023 per turn
// - sense false rotates left, true right
// - spin on rotates, off holds fixed angle
// - reference select takes speed from reference
// - reference edge sets angle to offset index, in reference-speed spin mode only
// - slew speed at rate, zero means immediate
// - report ticks between reference rising edges
// - report present angle index
// - return build date identifier word
// - report effective live step interval
// - hold mode walks stepwise toward fixed angle, jumps straight to it when the tick interval is zero
// - spin with reference keeps chosen sense
// - drive gain range code 0..7
// - table holds signed 14-bit amplitudes, peak 16383
// - angle core 40 MHz, serial drain 48 MHz
// - samples cross a 37-entry 32-bit queue
// - waveform kept in 1024-entry signed table
// - host queue words written into table
module resolver_angle_speed_generator
    import resolver_pkg::*;
#(
    parameter int unsigned QUEUE_DEPTH = 37,
    parameter int unsigned RAMP_TICKS  = `RAMP_TICKS_DEF,
    parameter logic [31:0] BUILD_DATE  = 32'h2000_0101  // arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [31:0] step_interval_ticks,
    input  wire logic [15:0] hold_angle_index,
    input  wire logic        rotation_sense,
    input  wire logic        spin_on,
    input  wire logic        ext_ref_speed_sel,
    input  wire logic [15:0] reference_angle_offset,
    input  wire logic [23:0] speed_slew_rate,
    input  wire logic        ref_in,
    input  wire logic [2:0]  gain_range_set,
    input  wire logic        table_load_request,
    input  wire logic        tbl_valid,
    input  wire logic [15:0] tbl_data,
    output logic             tbl_ready,
    output logic [31:0]      ref_edge_interval,
    output logic [31:0]      current_angle_index,
    output logic [31:0]      build_date_word,
    output logic [31:0]      live_step_interval,
    output logic [2:0]       gain_range_code,
    output logic             smp_valid,
    output logic [31:0]      smp_data,
    input  wire logic        smp_ready
);

    localparam int PTR_W = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
    localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);

    if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 1024) begin : g_bad_depth
        $error("QUEUE_DEPTH must lie between 2 and 1024");
    end
    if (RAMP_TICKS < 1) begin : g_bad_ramp
        $error("RAMP_TICKS must be at least 1");
    end

    // fractional divider: {pulse, next accumulator}
    function automatic logic [7:0] frac_step(input logic [6:0] acc, input logic [7:0] inc);
        logic [7:0] sum;
        sum = {1'b0, acc} + inc;
        if (sum >= `MCLK_MHZ) begin
            frac_step = {1'b1, 7'(sum - `MCLK_MHZ)};
        end else begin
            frac_step = {1'b0, sum[6:0]};
        end
    endfunction : frac_step

    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(QUEUE_DEPTH - 1)) begin
            ptr_next = '0;
        end else begin
            ptr_next = p + 1'b1;
        end
    endfunction : ptr_next

    // peaks beyond the 14-bit amplitude would overdrive the output converters
    function automatic sample_t clamp_amp(input sample_t v);
        if (v > `FULL_SCALE) begin
            clamp_amp = `FULL_SCALE;
        end else if (v < `NEG_FULL_SCALE) begin
            clamp_amp = `NEG_FULL_SCALE;
        end else begin
            clamp_amp = v;
        end
    endfunction : clamp_amp

    logic [6:0]  core_acc_q;
    logic        core_en_q;
    logic [6:0]  ser_acc_q;
    logic        ser_en_q;
    logic [7:0]  core_nx;
    logic [7:0]  ser_nx;
    logic        ref_d_q;
    logic        ref_rise;
    logic        ref_armed_q;
    logic        ref_ok_q;
    logic [31:0] ref_cnt_q;
    logic [31:0] ref_period_q;
    logic [31:0] ref_step;
    motion_mode_t mode;
    logic [31:0] target_ivl;
    logic [31:0] live_q;
    logic [31:0] ramp_cnt_q;
    logic        ramp_tick;
    logic [31:0] slew_delta;
    logic [31:0] step_cnt_q;
    logic        step_due;
    logic        step_fire;
    angle_t      angle_q;
    angle_t      angle_d;
    angle_t      hold_diff;
    angle_t      cos_idx;
    sample_t     waveform_ram [`TABLE_DEPTH];
    logic        load_req_q;
    logic        load_rise;
    logic [10:0] wr_ptr_q;
    logic [10:0] wr_ptr_d;
    logic [9:0]  wr_idx;
    logic        tbl_ready_q;
    logic        tbl_accept;
    sample_t     tbl_word;
    logic [31:0] queue_mem [QUEUE_DEPTH];
    logic [PTR_W-1:0] q_wr_q;
    logic [PTR_W-1:0] q_rd_q;
    logic [CNT_W-1:0] q_cnt_q;
    logic        q_full;
    logic        q_empty;
    logic        q_pop;
    logic [31:0] push_word;
    logic        smp_valid_q;
    logic [31:0] smp_data_q;
    logic [2:0]  gain_q;
    logic [31:0] build_q;

    assign core_nx = frac_step(core_acc_q, `CORE_CLK_MHZ);
    assign ser_nx  = frac_step(ser_acc_q, `SER_CLK_MHZ);

    // 40 MHz core and 48 MHz drain as enables of mclk, average rate exact
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            core_acc_q <= 7'h00;
            core_en_q  <= 1'b0;
            ser_acc_q  <= 7'h00;
            ser_en_q   <= 1'b0;
        end else begin
            core_acc_q <= core_nx[6:0];
            core_en_q  <= core_nx[7];
            ser_acc_q  <= ser_nx[6:0];
            ser_en_q   <= ser_nx[7];
        end
    end

    a_core_rate: assert property (@(posedge mclk) disable iff (!rst_b)
        core_en_q |=> !core_en_q ##1 (core_en_q || $past(core_en_q, 1) == 1'b0))
        else $error("core enable pulses too dense");

    // reference period, counted in 25 ns core ticks
    assign ref_rise = ref_in && !ref_d_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ref_d_q      <= 1'b0;
            ref_armed_q  <= 1'b0;
            ref_ok_q     <= 1'b0;
            ref_cnt_q    <= 32'h0000_0000;
            ref_period_q <= 32'h0000_0000;
        end else begin
            ref_d_q <= ref_in;
            if (ref_rise) begin
                ref_armed_q <= 1'b1;
                // a tick on the edge opens the new period, so no tick is lost or doubled
                ref_cnt_q   <= {31'h0000_0000, core_en_q};
                if (ref_armed_q) begin
                    ref_period_q <= ref_cnt_q;
                    ref_ok_q     <= 1'b1;
                end
            end else if (core_en_q && ref_cnt_q != 32'hFFFF_FFFF) begin
                ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
            end else if (ref_cnt_q == 32'hFFFF_FFFF) begin
                ref_ok_q <= 1'b0;  // reference lost: fall back to programmed interval
            end
        end
    end

    a_ref_capture: assert property (@(posedge mclk) disable iff (!rst_b)
        ref_rise && ref_armed_q
        |=> ref_edge_interval == $past(ref_cnt_q) && ref_cnt_q == {31'h0000_0000, $past(core_en_q)})
        else $error("reference period not captured");

    always_comb begin
        if (!spin_on) begin
            mode = MODE_HOLD;
        end else if (ext_ref_speed_sel) begin
            mode = MODE_SPIN_REF;
        end else begin
            mode = MODE_SPIN_PROG;
        end
    end

    assign ref_step = ref_period_q >> `REF_STEP_SHIFT;

    always_comb begin
        case (mode)
            MODE_SPIN_REF: target_ivl = (ref_ok_q && ref_step != 32'h0) ? ref_step : step_interval_ticks;
            default:       target_ivl = step_interval_ticks;
        endcase
    end

    // slew works on the interval, so equal rate gives smaller rpm steps at low speed
    assign ramp_tick  = core_en_q && ramp_cnt_q == RAMP_TICKS - 1;
    assign slew_delta = {8'h00, speed_slew_rate};

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ramp_cnt_q <= 32'h0000_0000;
        end else if (ramp_tick) begin
            ramp_cnt_q <= 32'h0000_0000;
        end else if (core_en_q) begin
            ramp_cnt_q <= ramp_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            live_q <= `RST_INTERVAL;
        end else if (speed_slew_rate == 24'h00_0000) begin
            live_q <= target_ivl;
        end else if (ramp_tick) begin
            if (live_q < target_ivl) begin
                live_q <= (target_ivl - live_q > slew_delta) ? live_q + slew_delta : target_ivl;
            end else begin
                live_q <= (live_q - target_ivl > slew_delta) ? live_q - slew_delta : target_ivl;
            end
        end
    end

    a_slew_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        speed_slew_rate == 24'h0 |=> live_step_interval == $past(target_ivl))
        else $error("zero slew rate did not apply speed at once");

    // full queue holds the step, so no sample is dropped
    assign step_due  = (live_q <= 32'h0000_0001) || (step_cnt_q >= live_q - 32'h0000_0001);
    assign step_fire = core_en_q && step_due && !q_full;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            step_cnt_q <= 32'h0000_0000;
        end else if (step_fire) begin
            step_cnt_q <= 32'h0000_0000;
        end else if (core_en_q && !step_due) begin
            step_cnt_q <= step_cnt_q + 32'h0000_0001;
        end
    end

    always_comb begin
        angle_d   = angle_q;
        hold_diff = hold_angle_index[9:0] - angle_q;
        case (mode)
            MODE_HOLD: begin
                if (step_interval_ticks == 32'h0) begin
                    angle_d = hold_angle_index[9:0];
                end else if (step_fire && hold_diff != 10'h000) begin
                    angle_d = hold_diff[9] ? angle_q - 10'h001 : angle_q + 10'h001;
                end
            end
            MODE_SPIN_PROG, MODE_SPIN_REF: begin
                if (mode == MODE_SPIN_REF && ref_rise) begin
                    angle_d = reference_angle_offset[9:0];
                end else if (step_fire) begin
                    angle_d = rotation_sense ? angle_q + 10'h001 : angle_q - 10'h001;
                end
            end
            default: angle_d = angle_q;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            angle_q <= `RST_ANGLE;
        end else begin
            angle_q <= angle_d;
        end
    end

    a_hold_walk: assert property (@(posedge mclk) disable iff (!rst_b)
        mode == MODE_HOLD && step_interval_ticks != 32'h0
        |=> angle_q == $past(angle_q) || angle_q == $past(angle_q) + 10'h001
            || angle_q == $past(angle_q) - 10'h001)
        else $error("hold mode jumped instead of stepping");

    a_spin_right: assert property (@(posedge mclk) disable iff (!rst_b)
        mode == MODE_SPIN_PROG && rotation_sense && step_fire |=> angle_q == $past(angle_q) + 10'h001)
        else $error("right rotation did not increment");

    a_spin_left: assert property (@(posedge mclk) disable iff (!rst_b)
        spin_on && !rotation_sense && step_fire && !(ext_ref_speed_sel && ref_rise)
        |=> angle_q == $past(angle_q) - 10'h001)
        else $error("left rotation did not decrement");

    a_ref_phase: assert property (@(posedge mclk) disable iff (!rst_b)
        mode == MODE_SPIN_REF && ref_rise |=> angle_q == $past(reference_angle_offset[9:0]))
        else $error("reference edge did not set the offset angle");

    // table reload: a rising request restarts the write pointer
    assign load_rise  = table_load_request && !load_req_q;
    assign tbl_accept = tbl_valid && tbl_ready_q;
    assign tbl_word   = clamp_amp(tbl_data);
    assign wr_idx     = wr_ptr_q[9:0];

    always_comb begin
        if (load_rise) begin
            wr_ptr_d = 11'h000;
        end else if (tbl_accept) begin
            wr_ptr_d = wr_ptr_q + 11'h001;
        end else begin
            wr_ptr_d = wr_ptr_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            load_req_q  <= 1'b0;
            wr_ptr_q    <= 11'h000;
            tbl_ready_q <= 1'b0;
        end else begin
            load_req_q  <= table_load_request;
            wr_ptr_q    <= wr_ptr_d;
            tbl_ready_q <= table_load_request && wr_ptr_d < `TABLE_DEPTH;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < `TABLE_DEPTH; i++) begin
                waveform_ram[i] <= 16'sh0000;
            end
        end else if (tbl_accept) begin
            waveform_ram[wr_idx] <= tbl_word;
        end
    end

    a_table_write: assert property (@(posedge mclk) disable iff (!rst_b)
        tbl_accept |=> waveform_ram[$past(wr_idx)] == $past(tbl_word) && wr_ptr_q == $past(wr_ptr_q) + 11'h001)
        else $error("table word not written at the write pointer");

    // sample word: sine in the upper half, cosine in the lower
    assign cos_idx   = angle_d + `QUARTER_TURN;
    assign push_word = {waveform_ram[angle_d], waveform_ram[cos_idx]};

    assign q_full  = q_cnt_q == CNT_W'(QUEUE_DEPTH);
    assign q_empty = q_cnt_q == '0;
    assign q_pop   = ser_en_q && !q_empty && (!smp_valid_q || smp_ready);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q_wr_q  <= '0;
            q_rd_q  <= '0;
            q_cnt_q <= '0;
        end else begin
            if (step_fire) begin
                queue_mem[q_wr_q] <= push_word;
                q_wr_q            <= ptr_next(q_wr_q);
            end
            if (q_pop) begin
                q_rd_q <= ptr_next(q_rd_q);
            end
            if (step_fire && !q_pop) begin
                q_cnt_q <= q_cnt_q + 1'b1;
            end else if (q_pop && !step_fire) begin
                q_cnt_q <= q_cnt_q - 1'b1;
            end
        end
    end

    a_queue_stall: assert property (@(posedge mclk) disable iff (!rst_b)
        q_full |-> !step_fire ##1 q_cnt_q <= CNT_W'(QUEUE_DEPTH))
        else $error("sample pushed into a full queue");

    // serial drain at the 48 MHz rate; receiver stall holds the word
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            smp_valid_q <= 1'b0;
            smp_data_q  <= 32'h0000_0000;
        end else if (q_pop) begin
            smp_valid_q <= 1'b1;
            smp_data_q  <= queue_mem[q_rd_q];
        end else if (smp_ready) begin
            smp_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gain_q  <= 3'h0;
            build_q <= BUILD_DATE;
        end else begin
            gain_q  <= gain_range_set;
            build_q <= BUILD_DATE;
        end
    end

    a_gain_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        ##1 gain_range_code == $past(gain_range_set))
        else $error("gain range code does not follow its setting");

    assign tbl_ready           = tbl_ready_q;
    assign ref_edge_interval   = ref_period_q;
    assign current_angle_index = {22'h00_0000, angle_q};
    assign build_date_word     = build_q;
    assign live_step_interval  = live_q;
    assign gain_range_code     = gain_q;
    assign smp_valid           = smp_valid_q;
    assign smp_data            = smp_data_q;

endmodule : resolver_angle_speed_generator

/* resolver_consts.svh */
// timing counts, table geometry and reset values for the resolver angle generator
`ifndef RESOLVER_CONSTS_SVH
`define RESOLVER_CONSTS_SVH

// clock rates in MHz; both slower domains are fractional enables of mclk
`define MCLK_MHZ        8'h64
`define CORE_CLK_MHZ    8'h28
`define SER_CLK_MHZ     8'h30

// ramp update period, in ns, and its count of 25 ns core ticks
`define RAMP_PERIOD_NS  1000000
`define RAMP_TICKS_DEF  ((`RAMP_PERIOD_NS * 40) / 1000)

// waveform table
`define TABLE_DEPTH     11'h400
`define QUARTER_TURN    10'h100
`define FULL_SCALE      16'sh3FFF
`define NEG_FULL_SCALE  16'shC001

// reference period to per-step interval: one turn is 1024 steps
`define REF_STEP_SHIFT  10

// reset values
`define RST_ANGLE       10'h000
`define RST_INTERVAL    32'h0000_0000

`endif

/* resolver_pkg.sv */
// types shared by the resolver angle generator
package resolver_pkg;

    typedef enum logic [1:0] {
        MODE_HOLD,
        MODE_SPIN_PROG,
        MODE_SPIN_REF
    } motion_mode_t;

    typedef logic [9:0]         angle_t;
    typedef logic signed [15:0] sample_t;

endpackage : resolver_pkg

/* sample_sink.sv */
// sample consumer standing in for the serial converter side
`timescale 1ns/1ps
module sample_sink (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        stall,
    input  wire logic        slow,
    input  wire logic        smp_valid,
    input  wire logic [31:0] smp_data,
    output logic             smp_ready
);
    logic [31:0] got[$];
    logic        phase_q;

    // slow mode takes a word only every other cycle, like a busy converter
    always @(posedge mclk) begin
        if (!rst_b) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            if (smp_valid && smp_ready) begin
                got.push_back(smp_data);
            end
        end
    end

    assign smp_ready = rst_b && !stall && (!slow || phase_q);
endmodule : sample_sink

/* testbench.sv */
// self-checking bench for the resolver angle and speed generator
`timescale 1ns/1ps
module testbench;
    import resolver_pkg::*;
    localparam logic [31:0] BUILD_DATE_TB = 32'h1357_2468;  // arbitrary value
    localparam int          REF_PERIOD    = 12500;
    localparam int          TIMEOUT       = 60000;
    typedef struct packed {
        logic [2:0]  gain;
        logic [15:0] hold;
        logic [2:0]  exp_gain;
        logic [31:0] exp_angle;
    } row_t;

    logic        mclk, rst_b, rotation_sense, spin_on, ext_ref_speed_sel, ref_in;
    logic        table_load_request, tbl_valid, tbl_ready, smp_valid, smp_ready, stall, slow;
    logic [31:0] step_interval_ticks, ref_edge_interval, current_angle_index;
    logic [31:0] build_date_word, live_step_interval, smp_data, held;
    logic [15:0] hold_angle_index, reference_angle_offset, tbl_data;
    logic [23:0] speed_slew_rate;
    logic [2:0]  gain_range_set, gain_range_code;
    logic [15:0] model [1024];
    row_t        rows [8];
    int          error_cnt, n_compared, cycle_cnt;

    resolver_angle_speed_generator #(.RAMP_TICKS(4), .BUILD_DATE(BUILD_DATE_TB)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .step_interval_ticks(step_interval_ticks),
        .hold_angle_index(hold_angle_index), .rotation_sense(rotation_sense), .spin_on(spin_on),
        .ext_ref_speed_sel(ext_ref_speed_sel), .reference_angle_offset(reference_angle_offset),
        .speed_slew_rate(speed_slew_rate), .ref_in(ref_in), .gain_range_set(gain_range_set),
        .table_load_request(table_load_request), .tbl_valid(tbl_valid), .tbl_data(tbl_data),
        .tbl_ready(tbl_ready), .ref_edge_interval(ref_edge_interval),
        .current_angle_index(current_angle_index), .build_date_word(build_date_word),
        .live_step_interval(live_step_interval), .gain_range_code(gain_range_code),
        .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready));

    sample_sink sink_u (.mclk(mclk), .rst_b(rst_b), .stall(stall), .slow(slow),
        .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready));

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // words 0 and 1023 lie outside the 14-bit range and must come back clamped
    function automatic logic [15:0] word_of(input int n);
        if (n == 0) return 16'h7FFF;
        if (n == 1023) return 16'h8000;
        return n[15:0];
    endfunction : word_of

    task automatic load_table();
        int n;
        n = 0;
        check("ready idle", tbl_ready, 1'b0);
        table_load_request <= 1'b1;
        tbl_valid          <= 1'b1;
        tbl_data           <= word_of(0);
        while (n < 1024) begin
            @(posedge mclk);
            if (tbl_ready === 1'b1) begin
                n++;
                tbl_data <= word_of(n);
            end
        end
        tbl_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        check("ready full", tbl_ready, 1'b0);
        table_load_request <= 1'b0;
    endtask : load_table

    // dir 0 checks only the sine/cosine pairing, else also the step per word;
    // rep lets a word repeat, as hold mode keeps pushing its resting angle
    task automatic check_samples(input int dir, input bit rep = 1'b0);
        logic [9:0]  a, prev, nxt;
        logic [15:0] s;
        prev = 10'h000;
        for (int i = 0; i < sink_u.got.size(); i++) begin
            s = sink_u.got[i][31:16];
            a = (s == 16'h3FFF) ? 10'h000 : (s == 16'hC001) ? 10'h3FF : s[9:0];
            check("cosine", sink_u.got[i][15:0], model[a + 10'h100]);
            nxt = prev + dir[9:0];
            if (dir != 0 && i > 0 && !(rep && a == prev)) check("step", a, nxt);
            prev = a;
        end
        sink_u.got.delete();
    endtask : check_samples

    // huge interval freezes stepping so the queue drains before the next mode
    task automatic settle();
        step_interval_ticks <= 32'hFFFF_FFFF;
        stall               <= 1'b0;
        slow                <= 1'b0;
        repeat (250) @(posedge mclk);
    endtask : settle

    task automatic ref_pulse(input logic [31:0] exp_iv);
        ref_in <= 1'b1;
        repeat (2) @(posedge mclk);
        check("ref angle", current_angle_index, 32'h64);
        check("ref period", ref_edge_interval, exp_iv);
        repeat (3) @(posedge mclk);
        ref_in <= 1'b0;
        repeat (40) @(posedge mclk);
        check("ref spin", current_angle_index > 100 && current_angle_index < 130, 1'b1);
        repeat (REF_PERIOD - 45) @(posedge mclk);
    endtask : ref_pulse

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == TIMEOUT) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        {rst_b, rotation_sense, spin_on, ext_ref_speed_sel, ref_in} = 5'h00;
        {table_load_request, tbl_valid, stall, slow} = 4'h0;
        {step_interval_ticks, hold_angle_index, reference_angle_offset} = 64'h0;
        {speed_slew_rate, gain_range_set, tbl_data} = 43'h0;
        {error_cnt, n_compared, cycle_cnt} = '0;
        for (int i = 0; i < 1024; i++) model[i] = i[15:0];
        model[0]    = 16'h3FFF;
        model[1023] = 16'hC001;
        rows = '{'{3'h0, 16'h0000, 3'h0, 32'h000}, '{3'h1, 16'h03FF, 3'h1, 32'h3FF},
                 '{3'h2, 16'h0200, 3'h2, 32'h200}, '{3'h3, 16'h0100, 3'h3, 32'h100},
                 '{3'h4, 16'h0001, 3'h4, 32'h001}, '{3'h5, 16'h02FF, 3'h5, 32'h2FF},
                 '{3'h6, 16'h03FE, 3'h6, 32'h3FE}, '{3'h7, 16'h0003, 3'h7, 32'h003}};
        repeat (8) @(posedge mclk);
        check("date", build_date_word, BUILD_DATE_TB);
        check("angle rst", current_angle_index, 32'h0);
        check("flags rst", {smp_valid, tbl_ready, gain_range_code}, 5'h00);
        check("iv rst", live_step_interval | ref_edge_interval, 32'h0);
        rst_b <= 1'b1;
        load_table();
        // words pushed before the table was filled carry stale entries
        sink_u.got.delete();
        foreach (rows[i]) begin
            gain_range_set   <= rows[i].gain;
            hold_angle_index <= rows[i].hold;
            repeat (12) @(posedge mclk);
            check("gain", gain_range_code, rows[i].exp_gain);
            check("hold", current_angle_index, rows[i].exp_angle);
        end
        repeat (20) @(posedge mclk);
        check_samples(0);
        step_interval_ticks <= 32'h3;
        hold_angle_index    <= 16'h03FC;
        repeat (12) @(posedge mclk);
        check("walk", current_angle_index < 4 || current_angle_index > 1020, 1'b1);
        repeat (200) @(posedge mclk);
        check("walk end", current_angle_index, 32'h3FC);
        settle();
        check_samples(-1, 1'b1);
        spin_on             <= 1'b1;
        rotation_sense      <= 1'b1;
        slow                <= 1'b1;
        step_interval_ticks <= 32'h3;
        repeat (300) @(posedge mclk);
        settle();
        check_samples(1);
        step_interval_ticks <= 32'h0;
        stall               <= 1'b1;
        repeat (300) @(posedge mclk);
        held = current_angle_index;
        repeat (100) @(posedge mclk);
        check("stalled", current_angle_index, held);
        stall <= 1'b0;
        repeat (300) @(posedge mclk);
        settle();
        check_samples(1);
        rotation_sense      <= 1'b0;
        step_interval_ticks <= 32'h0;
        slow                <= 1'b1;
        repeat (2500) @(posedge mclk);
        settle();
        check_samples(-1);
        rotation_sense      <= 1'b1;
        step_interval_ticks <= 32'h3;
        repeat (5) @(posedge mclk);
        check("live now", live_step_interval, 32'h3);
        speed_slew_rate     <= 24'h2;
        step_interval_ticks <= 32'hD;
        repeat (3) @(posedge mclk);
        check("ramp start", live_step_interval <= 5, 1'b1);
        repeat (300) @(posedge mclk);
        check("ramp end", live_step_interval, 32'hD);
        speed_slew_rate <= 24'h0;
        settle();
        check_samples(1);
        ext_ref_speed_sel      <= 1'b1;
        reference_angle_offset <= 16'h0064;
        step_interval_ticks    <= 32'h8;
        ref_pulse(32'h0);
        ref_pulse(32'h1388);
        check("ref live", live_step_interval, 32'h4);
        ext_ref_speed_sel <= 1'b0;
        settle();
        check_samples(0);
        complete_run();
    end
endmodule : testbench
